// file: core/wdog_pkg.sv
// Shared constants for the watchdog block: register map, field layout, reset values
// Assumes a byte-addressed APB slave with 32-bit data, one register per word
package wdog_pkg;

  localparam int APB_AW = 8;

  // Register byte addresses
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CFG = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_CAUSE = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = 8'h10;

  // Field positions
  localparam int CTRL_SW_EN_BIT = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_PS_LSB = 1;
  localparam int PS_W = 3;
  localparam int PS_CNT_W = 7;
  localparam int CAUSE_IPE_BIT = 7;
  localparam int CAUSE_RESET_INSTR_BIT = 4;
  localparam int CAUSE_TIMEOUT_BIT = 3;
  localparam int CAUSE_PDOWN_BIT = 2;
  localparam int CAUSE_PON_BIT = 1;
  localparam int CAUSE_BROWN_BIT = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_RST_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_SLEEP_BIT = 2;

  // Reset values and masks
  localparam logic [7:0] CAUSE_SW_MASK = 8'h93;
  localparam logic [7:0] CAUSE_RESET = 8'h1C;
  localparam logic [7:0] CFG_UNPROG = 8'h0F;
  localparam logic [1:0] CFG_SETTLE = 2'h2;

  // Last postscaler count for a select code: ratio 2**sel, minus one
  function automatic logic [PS_CNT_W-1:0] ratio_last(input logic [PS_W-1:0] sel);
    ratio_last = PS_CNT_W'((8'h01 << sel) - 8'h01);
  endfunction

endpackage

// file: core/wdog_link_if.sv
// Signals between the processor-clock side and the RC-oscillator counter
// Assumes each side drives its outputs from flip-flops; the reader synchronises
`timescale 1ns/1ps
interface wdog_link_if;
  import wdog_pkg::*;
  logic run;
  logic asleep;
  logic clr_tgl;
  logic [PS_W-1:0] ps_sel;
  logic timeout_tgl;
  logic wake;
  modport sys (output run, asleep, clr_tgl, ps_sel, input timeout_tgl, wake);
  modport rc (input run, asleep, clr_tgl, ps_sel, output timeout_tgl, wake);
endinterface

// file: core/wdog_sync.sv
// Two-flop level synchroniser, W bits wide
// Assumes each bit is a slow level or a toggle from a flip-flop
`timescale 1ns/1ps
module wdog_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // wdog_sync

// file: core/wdog_rc_counter.sv
// Watchdog counter and postscaler on the free-running RC oscillator clock
// Assumes the RC clock runs whenever the device is powered
`timescale 1ns/1ps
module wdog_rc_counter
  import wdog_pkg::*;
#(
  parameter int BASE_COUNT = 1024
) (
  input wire logic rc_clk,
  input wire logic rst,
  wdog_link_if.rc lnk
);
  localparam int CNT_W = $clog2(BASE_COUNT + 1);
  localparam logic [CNT_W-1:0] BASE_LAST = CNT_W'(BASE_COUNT - 1);

  logic run_s, asleep_s, clr_s;
  logic [PS_W-1:0] ps_s;
  logic clr_seen_reg, timeout_tgl_reg, wake_reg;
  logic [CNT_W-1:0] base_cnt_reg;
  logic [PS_CNT_W-1:0] ps_cnt_reg;
  logic clear, base_end, timeout;

  wdog_sync #(.W(PS_W + 3)) u_sync (
    .clk(rc_clk),
    .rst(rst),
    .d({lnk.run, lnk.asleep, lnk.clr_tgl, lnk.ps_sel}),
    .q({run_s, asleep_s, clr_s, ps_s})
  );

  assign clear = clr_s ^ clr_seen_reg;
  assign base_end = base_cnt_reg == BASE_LAST;
  assign timeout = run_s && !clear && base_end && ps_cnt_reg >= ratio_last(ps_s);

  always_ff @(posedge rc_clk or posedge rst) begin
    if (rst) begin
      clr_seen_reg <= 1'b0;
    end else begin
      clr_seen_reg <= clr_s;
    end
  end

  // Base counter and postscaler, both zeroed by a clear
  always_ff @(posedge rc_clk or posedge rst) begin
    if (rst) begin
      base_cnt_reg <= '0;
      ps_cnt_reg <= '0;
    end else if (clear || !run_s) begin
      base_cnt_reg <= '0;
      ps_cnt_reg <= '0;
    end else if (base_end) begin
      base_cnt_reg <= '0;
      ps_cnt_reg <= timeout ? '0 : ps_cnt_reg + 1'b1;
    end else begin
      base_cnt_reg <= base_cnt_reg + 1'b1;
    end
  end

  // Time-out event and wake, both usable with the processor clock stopped
  always_ff @(posedge rc_clk or posedge rst) begin
    if (rst) begin
      timeout_tgl_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      if (timeout) begin
        timeout_tgl_reg <= !timeout_tgl_reg;
      end
      if (timeout && asleep_s) begin
        wake_reg <= 1'b1;
      end else if (!asleep_s) begin
        wake_reg <= 1'b0;
      end
    end
  end

  assign lnk.timeout_tgl = timeout_tgl_reg;
  assign lnk.wake = wake_reg;

  ratio_end_a: assert property (@(posedge rc_clk) disable iff (rst)
    $changed(timeout_tgl_reg) |-> $past(base_end) && $past(ps_cnt_reg) == $past(ratio_last(ps_s)))
    else $error("time-out not at postscaler end");
  clear_zero_a: assert property (@(posedge rc_clk) disable iff (rst)
    clear |=> base_cnt_reg == '0 && ps_cnt_reg == '0 && $stable(timeout_tgl_reg))
    else $error("clear did not zero counters");
  sleep_wake_a: assert property (@(posedge rc_clk) disable iff (rst)
    timeout && asleep_s |=> wake_reg)
    else $error("no wake on sleeping time-out");
endmodule // wdog_rc_counter

// file: core/wdog_timer.sv
// Watchdog timer top: APB registers, reset and wake control, interrupt
// Assumes SYS_CLK at 125 MHz, RC_CLK from a free-running on-chip RC oscillator,
// and core instruction strobes that are one SYS_CLK cycle long
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module wdog_timer
  import wdog_pkg::*;
#(
  parameter int BASE_COUNT = 1024
) (
  // Clocks and reset
  input wire logic SYS_CLK,
  input wire logic RC_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor core
  input wire logic CLEAR_WATCHDOG_INSTR,
  input wire logic SLEEP_INSTR,
  input wire logic EXT_WAKE,
  // Programmed configuration word
  input wire logic [7:0] CFG_WORD,
  // Reset, wake, oscillator and interrupt
  output logic WATCHDOG_RESET_REQ,
  output logic WAKE_REQ,
  output logic OSC_DRIVER_OFF,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  wdog_link_if lnk();

  logic ready_reg;
  logic slverr_reg;
  logic [31:0] prdata_reg;
  logic sw_en_reg;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_pin_s;
  logic [1:0] cfg_cnt_reg;
  logic cfg_done_reg;
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_evt;
  logic irq_reg;
  logic asleep_reg;
  logic reset_req_reg;
  logic run_reg;
  logic clr_tgl_reg;
  logic tgl_s;
  logic tgl_seen_reg;
  logic access;
  logic take;
  logic wr;
  logic sleep_go;
  logic clear_go;
  logic timeout_evt;
  logic [31:0] rd_word;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // RC-domain counter and crossings

  wdog_rc_counter #(.BASE_COUNT(BASE_COUNT)) u_counter (
    .rc_clk(RC_CLK),
    .rst(RST),
    .lnk(lnk.rc)
  );

  assign lnk.run = run_reg;
  assign lnk.asleep = asleep_reg;
  assign lnk.clr_tgl = clr_tgl_reg;
  assign lnk.ps_sel = cfg_reg[CFG_PS_LSB +: PS_W];

  wdog_sync #(.W(1)) u_tgl_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d(lnk.timeout_tgl),
    .q(tgl_s)
  );

  wdog_sync #(.W(8)) u_cfg_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d(CFG_WORD),
    .q(cfg_pin_s)
  );

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= tgl_s;
    end
  end

  assign timeout_evt = tgl_s ^ tgl_seen_reg;
  assign sleep_go = SLEEP_INSTR && !asleep_reg;
  assign clear_go = CLEAR_WATCHDOG_INSTR || sleep_go;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign access = PSEL && PENABLE;
  assign take = access && ready_reg;
  assign wr = take && PWRITE && !slverr_reg;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (PADDR)
      ADDR_CTRL: rd_word[CTRL_SW_EN_BIT] = sw_en_reg;
      ADDR_CFG: rd_word[7:0] = cfg_reg;
      ADDR_CAUSE: rd_word[7:0] = cause_reg;
      ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_reg;
      ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ready_reg <= access && !ready_reg;
      if (access && !ready_reg) begin
        slverr_reg <= !rd_hit;
        prdata_reg <= PWRITE ? 32'h0000_0000 : rd_word;
      end else begin
        slverr_reg <= 1'b0;
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Enables and configuration

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sw_en_reg <= 1'b0;
    end else if (wr && PADDR == ADDR_CTRL) begin
      sw_en_reg <= PWDATA[CTRL_SW_EN_BIT];
    end
  end

  // Programmed word caught once after reset, never written by software
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg_reg <= CFG_UNPROG;
      cfg_cnt_reg <= 2'h0;
      cfg_done_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      if (cfg_cnt_reg == CFG_SETTLE) begin
        cfg_reg <= cfg_pin_s;
        cfg_done_reg <= 1'b1;
      end else begin
        cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      run_reg <= 1'b0;
    end else begin
      // Off until the programmed word is in, so no count runs on a stale select
      run_reg <= cfg_done_reg && (cfg_reg[CFG_EN_BIT] || sw_en_reg);
    end
  end

  // Toggle carries each clear into the RC domain; select is untouched
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clr_tgl_reg <= 1'b0;
    end else if (clear_go) begin
      clr_tgl_reg <= !clr_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep, wake and reset request

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      asleep_reg <= 1'b0;
    end else if (timeout_evt || EXT_WAKE) begin
      asleep_reg <= 1'b0;
    end else if (sleep_go) begin
      asleep_reg <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= timeout_evt && !asleep_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset cause register; hardware updates win over software writes

  always_comb begin
    cause_next = cause_reg;
    if (wr && PADDR == ADDR_CAUSE) begin
      cause_next = (cause_reg & ~CAUSE_SW_MASK) | (PWDATA[7:0] & CAUSE_SW_MASK);
    end
    if (sleep_go) begin
      cause_next[CAUSE_PDOWN_BIT] = 1'b0;
      cause_next[CAUSE_TIMEOUT_BIT] = 1'b1;
    end
    if (timeout_evt) begin
      cause_next[CAUSE_TIMEOUT_BIT] = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cause_reg <= CAUSE_RESET;
    end else begin
      cause_reg <= cause_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; set wins

  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_RST_BIT] = timeout_evt && !asleep_reg;
    irq_evt[IRQ_WAKE_BIT] = timeout_evt && asleep_reg;
    irq_evt[IRQ_SLEEP_BIT] = sleep_go;
    irq_stat_next = irq_stat_reg;
    if (wr && PADDR == ADDR_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~PWDATA[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_evt;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr && PADDR == ADDR_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA = prdata_reg;
  assign PREADY = ready_reg;
  assign PSLVERR = slverr_reg;
  assign WATCHDOG_RESET_REQ = reset_req_reg;
  assign WAKE_REQ = lnk.wake;
  assign OSC_DRIVER_OFF = asleep_reg;
  assign IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  cfg_forced_on_a: assert property (cfg_done_reg && cfg_reg[CFG_EN_BIT] |=> run_reg)
    else $error("software stopped configured watchdog");
  sw_enable_a: assert property (
    cfg_done_reg && !cfg_reg[CFG_EN_BIT] ##1 !cfg_reg[CFG_EN_BIT] |-> run_reg == $past(sw_en_reg))
    else $error("run does not follow software enable");
  ctrl_read_a: assert property (
    take && !PWRITE && PADDR == ADDR_CTRL |-> PRDATA == {31'h0000_0000, sw_en_reg})
    else $error("control read wrong");
  reset_req_a: assert property (
    timeout_evt && !asleep_reg |=> WATCHDOG_RESET_REQ ##1 !WATCHDOG_RESET_REQ)
    else $error("no reset request on awake time-out");
  sleep_timeout_a: assert property (
    timeout_evt && asleep_reg |=> !WATCHDOG_RESET_REQ && !asleep_reg && irq_stat_reg[IRQ_WAKE_BIT])
    else $error("sleeping time-out did not wake");
  timeout_flag_a: assert property (timeout_evt |=> !cause_reg[CAUSE_TIMEOUT_BIT])
    else $error("time-out flag not cleared");
  sleep_entry_a: assert property (
    sleep_go && !timeout_evt && !EXT_WAKE |=> OSC_DRIVER_OFF && !cause_reg[CAUSE_PDOWN_BIT]
      && cause_reg[CAUSE_TIMEOUT_BIT] && clr_tgl_reg != $past(clr_tgl_reg))
    else $error("sleep entry wrong");
  clear_send_a: assert property (clear_go |=> clr_tgl_reg != $past(clr_tgl_reg))
    else $error("clear not sent");
  cfg_hold_a: assert property (cfg_done_reg |=> $stable(cfg_reg))
    else $error("configuration changed after load");
  irq_level_a: assert property (|(irq_stat_reg & irq_mask_reg) |=> IRQ)
    else $error("interrupt not raised");
  apb_ready_a: assert property (access && !ready_reg |=> PREADY ##1 !PREADY)
    else $error("APB answer timing wrong");
  irq_clear_a: assert property (!(|(irq_stat_reg & irq_mask_reg)) |=> !IRQ)
    else $error("interrupt not dropped");
  slverr_read_a: assert property (take && !rd_hit |-> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");
  cause_hw_bits_a: assert property (
    wr && PADDR == ADDR_CAUSE && !sleep_go && !timeout_evt |=>
      $stable(cause_reg[CAUSE_TIMEOUT_BIT]) && $stable(cause_reg[CAUSE_PDOWN_BIT]))
    else $error("software wrote a hardware flag");
  reset_cause_a: assert property (
    WATCHDOG_RESET_REQ |-> $past(timeout_evt) && !$past(asleep_reg))
    else $error("reset request without awake time-out");
  ext_wake_a: assert property (EXT_WAKE |=> !OSC_DRIVER_OFF)
    else $error("other wake source ignored");
  sw_write_a: assert property (
    wr && PADDR == ADDR_CTRL |=> sw_en_reg == $past(PWDATA[CTRL_SW_EN_BIT]))
    else $error("software enable write lost");

endmodule // wdog_timer

// file: sim/core_model.sv
// Processor core model: clear, sleep and wake strobes toward the watchdog
// Assumes strobes one SYS_CLK cycle long, sampled by the watchdog at rising edges
`timescale 1ns/1ps
module core_model (
  // Clock and core state
  input wire logic clk,
  input wire logic asleep,
  // Instruction strobes
  output logic clr,
  output logic slp,
  output logic wake
);
  initial begin
    clr = 1'b0;
    slp = 1'b0;
    wake = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halted core executes no instruction
  task exec_clear();
    if (!asleep) begin
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
    end
  endtask

  task exec_sleep();
    if (!asleep) begin
      @(posedge clk) slp <= 1'b1;
      @(posedge clk) slp <= 1'b0;
    end
  endtask

  // Other wake source, honoured while halted
  task raise_wake();
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
  endtask
endmodule // core_model

// file: sim/wdog_timer_tb.sv
// Self-checking bench for the watchdog: APB register tasks, core model strobes
// Assumes BASE_COUNT shortened to 4; SYS_CLK stopped by the bench during the sleep ended by time-out
`timescale 1ns/1ps
module wdog_timer_tb
  import wdog_pkg::*;
;
  localparam int BASE = 4;
  logic sys_clk = 1'b0;
  logic rc_clk = 1'b0;
  logic clk_run = 1'b1;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] cfg_word = 8'h0E;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clr;
  logic slp;
  logic wake;
  logic rst_req;
  logic wake_req;
  logic osc_off;
  logic irq;
  logic last_err;
  logic [31:0] rdat;
  logic hung = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  int n_rst = 0;
  int rc_cnt = 0;
  int rc_at = 0;
  int rc_prev = 0;
  int d;
  int i;

  wdog_timer #(.BASE_COUNT(BASE)) dut (.SYS_CLK(sys_clk), .RC_CLK(rc_clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CLEAR_WATCHDOG_INSTR(clr),
    .SLEEP_INSTR(slp), .EXT_WAKE(wake), .CFG_WORD(cfg_word), .WATCHDOG_RESET_REQ(rst_req),
    .WAKE_REQ(wake_req), .OSC_DRIVER_OFF(osc_off), .IRQ(irq));
  core_model core (.clk(sys_clk), .asleep(osc_off), .clr(clr), .slp(slp), .wake(wake));

  ////////////////////////////////////////////////////////////////////////////
  // Main clock stops low while clk_run is clear (time-out sleep only); RC clock never stops
  always #4 if (clk_run || sys_clk) sys_clk = ~sys_clk;
  always #6.5 rc_clk = ~rc_clk;
  always @(posedge rc_clk) rc_cnt++;
  always @(posedge sys_clk) begin
    if (rst_req === 1'b1) begin
      rc_prev = rc_at;
      rc_at = rc_cnt;
      n_rst++;
    end
  end
  always @(posedge hung) test_done();

  ////////////////////////////////////////////////////////////////////////////
  task test_done();
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task hang();
    n_errors++;
    hung = 1'b1;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bit_chk(input string name, input logic seen, input logic exp);
    chk(name, {31'h0, seen}, {31'h0, exp});
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) hang();
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [APB_AW-1:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task rd_chk(input string name, input logic [APB_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rdat, exp);
  endtask

  task wait_rst(input int bound, input int k);
    int j;
    j = 0;
    while (n_rst <= k && j < bound) begin
      @(posedge sys_clk);
      j++;
    end
    if (n_rst <= k) hang();
  endtask

  task do_reset(input logic [7:0] cfg);
    @(posedge sys_clk);
    rst <= 1'b1;
    cfg_word <= cfg;
    tick(4);
    rst <= 1'b0;
    n_rst = 0;
    tick(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // Software-enabled run, longest postscale
    do_reset(8'h0E);
    rd_chk("ctrl", ADDR_CTRL, 32'h0000_0000);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_001C);
    rd_chk("mask", ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk("stat", ADDR_IRQ_STAT, 32'h0000_0000);
    wr(ADDR_CTRL, 32'hFFFF_FFFF);
    rd_chk("ctrl", ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CFG, 32'h0000_0000);
    rd_chk("cfg", ADDR_CFG, 32'h0000_000E);
    wr(ADDR_CAUSE, 32'hFFFF_FFFF);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_009F);
    wr(ADDR_CAUSE, 32'h0000_0000);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_000C);
    apb(1'b0, 8'h20, 32'h0000_0000);
    bit_chk("slverr", last_err, 1'b1);
    chk("unmapped", rdat, 32'h0000_0000);
    tick(1500);
    chk("resets", 32'(n_rst), 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (5) begin
      tick(400);
      core.exec_clear();
    end
    chk("resets", 32'(n_rst), 32'h0000_0000);
    wait_rst(2000, 0);
    wr(ADDR_CTRL, 32'h0000_0000);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_0004);
    rd_chk("stat", ADDR_IRQ_STAT, 32'h0000_0001);
    rd_chk("cfg", ADDR_CFG, 32'h0000_000E);
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    // Sleep ended by the other wake source
    core.exec_sleep();
    tick(1);
    bit_chk("osc_off", osc_off, 1'b1);
    tick(50);
    core.raise_wake();
    tick(2);
    bit_chk("osc_off", osc_off, 1'b0);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_0008);
    rd_chk("stat", ADDR_IRQ_STAT, 32'h0000_0004);
    bit_chk("irq", irq, 1'b0);
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    // Sleep ended by time-out, main clock stopped meanwhile
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0001);
    core.exec_sleep();
    tick(1);
    clk_run = 1'b0;
    i = 0;
    while (wake_req !== 1'b1 && i < 1500) begin
      @(posedge rc_clk);
      i++;
    end
    bit_chk("wake", wake_req, 1'b1);
    clk_run = 1'b1;
    tick(4);
    wr(ADDR_CTRL, 32'h0000_0000);
    chk("resets", 32'(n_rst), 32'h0000_0001);
    bit_chk("osc_off", osc_off, 1'b0);
    bit_chk("irq", irq, 1'b1);
    rd_chk("cause", ADDR_CAUSE, 32'h0000_0000);
    rd_chk("stat", ADDR_IRQ_STAT, 32'h0000_0006);
    wr(ADDR_IRQ_STAT, 32'h0000_0002);
    tick(2);
    bit_chk("irq", irq, 1'b0);
    // Configuration-enabled runs, every postscale code
    for (int s = 0; s < 8; s++) begin
      do_reset({4'h0, 3'(s), 1'h1});
      wr(ADDR_CTRL, 32'h0000_0000);
      core.exec_clear();
      rd_chk("cfg", ADDR_CFG, {28'h000_0000, 3'(s), 1'h1});
      // Let any time-out from before the clear drain, then time two clean ones
      tick(8);
      wait_rst(3000, n_rst + 1);
      rd_chk("cause", ADDR_CAUSE, 32'h0000_0014);
      d = rc_at - rc_prev - BASE * (1 << s);
      bit_chk("ratio", 1'(d >= -1 && d <= 1), 1'b1);
    end
    test_done();
  end
endmodule // wdog_timer_tb
